// ---- design/irq_ctl_regs.svh ----
// Register map, field positions and timing counts of the interrupt control block
`ifndef IRQ_CTL_REGS_SVH
`define IRQ_CTL_REGS_SVH
// How it works
// - Pin B requests only with enable and global
// - Pin A requests only with enable and global
// - Pin activity counts even when driven out
// - Two sense bits choose level or edge
// - Sensed edge sets the pin flag
// - Entry or write-one clears pin flag
// - Level sensing holds the pin flag clear
// - Level request is never latched anywhere
// - Enabled low level requests while held low
// - Timer B wrap vectors when enabled
// - Compare match vectors when enabled
// - Capture event vectors when enabled
// - Timer A wrap vectors when enabled
// - Timer B wrap flag set, cleared
// - Pulse-width bottom reversal sets wrap flag
// - Compare flag set on match, cleared
// - Capture flag set after copy, cleared
// - Timer A wrap flag set, cleared
// - Entry takes four cycles, two pushes
// - Finish current instruction before entry
// - Return takes four cycles, pops, sets global
// - One main instruction after return first
// - Sense code 00 low, 10 fall, 11 rise
// - Entry clears global enable, return sets

// Register indices; byte address is four times the index
`define IRQ_MCU_CTRL_IDX 6'h35
`define IRQ_EXT_MASK_IDX 6'h3B
`define IRQ_EXT_FLAG_IDX 6'h3A
`define IRQ_TMR_MASK_IDX 6'h39
`define IRQ_TMR_FLAG_IDX 6'h38
`define IRQ_STATUS_IDX 6'h3F
// Writable bits and reset value
`define IRQ_MCU_CTRL_WMASK 8'h3F
`define IRQ_EXT_MASK_WMASK 8'hC0
`define IRQ_TMR_MASK_WMASK 8'hCA
`define IRQ_REG_RESET 8'h00
// Field positions
`define IRQ_PIN_B_BIT 7
`define IRQ_PIN_A_BIT 6
`define IRQ_TB_WRAP_BIT 7
`define IRQ_CMP_BIT 6
`define IRQ_CAP_BIT 3
`define IRQ_TA_WRAP_BIT 1
`define IRQ_GIE_BIT 7
// Sense codes
`define IRQ_SENSE_LEVEL 2'h0
`define IRQ_SENSE_FALL 2'h2
`define IRQ_SENSE_RISE 2'h3
// Vector of the highest priority source; the rest follow by one
`define IRQ_VEC_BASE 10'h001
// Entry and return lengths in clock cycles
`define IRQ_ENTRY_CYCLES 3'h4
`define IRQ_RET_CYCLES 3'h4
`endif

// ---- design/irq_ctl_pkg.sv ----
// Types shared by the interrupt control block
package irq_ctl_pkg;
  // Sequencer states, one-hot
  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_ENTRY = 4'h2,
    S_RET = 4'h4,
    S_HOLD = 4'h8
  } seq_state_t;
  // Same-clock event strobes from the two timers
  typedef struct packed {
    logic tbWrap;
    logic tbPwmBottom;
    logic compare;
    logic captured;
    logic taWrap;
  } timer_evt_t;
  // Requests from the core
  typedef struct packed {
    logic instrBoundary;
    logic returnReq;
  } core_req_t;
  // Answers to the core
  typedef struct packed {
    logic vecValid;
    logic [9:0] vecAddr;
    logic push;
    logic pop;
  } core_ans_t;
  // Whole state of the controller
  typedef struct packed {
    seq_state_t fsm;
    logic [2:0] cnt;
    logic [7:0] mcuCtrl;
    logic [7:0] extMask;
    logic [7:0] extFlag;
    logic [7:0] tmrMask;
    logic [7:0] tmrFlag;
    logic gie;
    logic [31:0] prdata;
    core_ans_t ans;
  } ctl_state_t;
  // State of one pin sense unit
  typedef struct packed {
    logic sync1;
    logic sync2;
    logic prev;
  } sense_state_t;
endpackage

// ---- design/ext_pin_sense.sv ----
// Synchroniser and edge or level sense for one external interrupt pin
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctl_regs.svh"
module ext_pin_sense (
  input wire logic clk,
  input wire logic nrst,
  input wire logic pin,
  input wire logic [1:0] senseMode,
  output logic edgeHit,
  output logic levelLow
);
  irq_ctl_pkg::sense_state_t q; // Registered state
  irq_ctl_pkg::sense_state_t d; // Next state

  // Sync chain; the pad level is read whatever the pin direction
  always_comb
  begin
    d = q;
    d.sync1 = pin;
    d.sync2 = q.sync1;
    d.prev = q.sync2;
  end

  // State register
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      q <= '0;
    else
      q <= d;
  end

  // Edge pick from the sense code; reserved code gives nothing
  always_comb
  begin
    edgeHit = 1'b0;
    if (senseMode == `IRQ_SENSE_FALL)
      edgeHit = q.prev & ~q.sync2;
    else if (senseMode == `IRQ_SENSE_RISE)
      edgeHit = ~q.prev & q.sync2;
  end

  // Level is live only, no memory of it
  assign levelLow = (senseMode == `IRQ_SENSE_LEVEL) & ~q.sync2;
endmodule
`default_nettype wire

// ---- design/irq_ctl.sv ----
// Interrupt mask, flag, sense control and entry/return sequencer
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctl_regs.svh"
module irq_ctl (
  input wire logic clk,
  input wire logic nrst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // External pins, asynchronous
  input wire logic extIrqPinA,
  input wire logic extIrqPinB,
  // Timer strobes, same clock
  input wire irq_ctl_pkg::timer_evt_t timerEvt,
  // Core side
  input wire irq_ctl_pkg::core_req_t coreReq,
  output irq_ctl_pkg::core_ans_t coreAns,
  output logic globalEnable
);
  // ****************************************
  // Declarations
  // ****************************************
  irq_ctl_pkg::ctl_state_t q; // Registered state
  irq_ctl_pkg::ctl_state_t d; // Next state
  logic edgeA; // Pin A edge event
  logic edgeB; // Pin B edge event
  logic levelA; // Pin A held low in level mode
  logic levelB; // Pin B held low in level mode
  logic [5:0] req; // Enabled sources, bit 0 is top priority
  logic [2:0] sel; // Winning source
  logic take; // Entry starts this cycle
  logic retTake; // Return starts this cycle
  logic [5:0] idx; // Word index on the bus
  logic hit; // Address maps to a register
  logic wr; // Write strobe
  logic [7:0] rdMux; // Read data
  logic [7:0] wdat; // Write byte
  logic [7:0] clrExt; // Pin flag clears
  logic [7:0] clrTmr; // Timer flag clears
  logic [7:0] setExt; // Pin flag sets
  logic [7:0] setTmr; // Timer flag sets

  // ****************************************
  // Pin sense units
  // ****************************************
  // Pin A uses the low sense pair
  ext_pin_sense senseA (
    .clk(clk),
    .nrst(nrst),
    .pin(extIrqPinA),
    .senseMode(q.mcuCtrl[1:0]),
    .edgeHit(edgeA),
    .levelLow(levelA)
  );
  // Pin B uses the high sense pair
  ext_pin_sense senseB (
    .clk(clk),
    .nrst(nrst),
    .pin(extIrqPinB),
    .senseMode(q.mcuCtrl[3:2]),
    .edgeHit(edgeB),
    .levelLow(levelB)
  );

  // ****************************************
  // Bus decode
  // ****************************************
  assign idx = paddr[7:2];
  assign wdat = pwdata[7:0];
  assign wr = psel & penable & pwrite & hit;
  // Zero wait states: the read word is fetched in setup
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~hit;
  assign prdata = q.prdata;
  assign coreAns = q.ans;
  assign globalEnable = q.gie;

  // Address map and read data
  always_comb
  begin
    hit = 1'b1;
    rdMux = 8'h00;
    unique case (idx)
      `IRQ_MCU_CTRL_IDX: rdMux = q.mcuCtrl;
      `IRQ_EXT_MASK_IDX: rdMux = q.extMask;
      `IRQ_EXT_FLAG_IDX: rdMux = q.extFlag;
      `IRQ_TMR_MASK_IDX: rdMux = q.tmrMask;
      `IRQ_TMR_FLAG_IDX: rdMux = q.tmrFlag;
      `IRQ_STATUS_IDX: rdMux = {q.gie, 7'h00};
      default: hit = 1'b0;
    endcase
  end

  // ****************************************
  // Request and priority
  // ****************************************
  // Each source needs its own enable; the global gate comes at take
  always_comb
  begin
    // Level request bypasses the flag, live only
    req[0] = (q.extFlag[`IRQ_PIN_A_BIT] | levelA)
      & q.extMask[`IRQ_PIN_A_BIT];
    req[1] = (q.extFlag[`IRQ_PIN_B_BIT] | levelB)
      & q.extMask[`IRQ_PIN_B_BIT];
    req[2] = q.tmrFlag[`IRQ_CAP_BIT] & q.tmrMask[`IRQ_CAP_BIT];
    req[3] = q.tmrFlag[`IRQ_CMP_BIT] & q.tmrMask[`IRQ_CMP_BIT];
    req[4] = q.tmrFlag[`IRQ_TB_WRAP_BIT]
      & q.tmrMask[`IRQ_TB_WRAP_BIT];
    req[5] = q.tmrFlag[`IRQ_TA_WRAP_BIT]
      & q.tmrMask[`IRQ_TA_WRAP_BIT];
  end

  // Lowest vector wins: scan from the top index down, last hit kept
  always_comb
  begin
    sel = 3'h0;
    for (int i = 5; i >= 0; i--)
    begin
      if (req[i])
        sel = 3'(i);
    end
  end

  // Entry only at an instruction end, so a long one finishes
  assign take = (q.fsm == irq_ctl_pkg::S_IDLE) & coreReq.instrBoundary
    & q.gie & (|req) & ~coreReq.returnReq;
  // Return is decoded by the core and handed over here
  assign retTake = (q.fsm == irq_ctl_pkg::S_IDLE) & coreReq.returnReq;

  // ****************************************
  // Flag set and clear terms
  // ****************************************
  // Hardware clear on entry for the served flag; level has none
  always_comb
  begin
    clrExt = 8'h00;
    clrTmr = 8'h00;
    // Software clear, write one; zero leaves the bit
    if (wr && idx == `IRQ_EXT_FLAG_IDX)
      clrExt = wdat;
    // Timer flags share the write-one clear
    if (wr && idx == `IRQ_TMR_FLAG_IDX)
      clrTmr = wdat;
    if (take)
    begin
      unique case (sel)
        3'h0: clrExt[`IRQ_PIN_A_BIT] = 1'b1;
        3'h1: clrExt[`IRQ_PIN_B_BIT] = 1'b1;
        3'h2: clrTmr[`IRQ_CAP_BIT] = 1'b1;
        3'h3: clrTmr[`IRQ_CMP_BIT] = 1'b1;
        3'h4: clrTmr[`IRQ_TB_WRAP_BIT] = 1'b1;
        3'h5: clrTmr[`IRQ_TA_WRAP_BIT] = 1'b1;
        default: clrTmr = clrTmr;
      endcase
    end
  end

  // Event sets
  always_comb
  begin
    setExt = 8'h00;
    setTmr = 8'h00;
    setExt[`IRQ_PIN_A_BIT] = edgeA;
    setExt[`IRQ_PIN_B_BIT] = edgeB;
    // Overflow or bottom reversal in pulse-width mode
    setTmr[`IRQ_TB_WRAP_BIT] = timerEvt.tbWrap | timerEvt.tbPwmBottom;
    setTmr[`IRQ_CMP_BIT] = timerEvt.compare;
    setTmr[`IRQ_CAP_BIT] = timerEvt.captured;
    setTmr[`IRQ_TA_WRAP_BIT] = timerEvt.taWrap;
  end

  // ****************************************
  // Next state
  // ****************************************
  always_comb
  begin
    d = q;
    d.ans.vecValid = 1'b0;
    d.ans.push = 1'b0;
    d.ans.pop = 1'b0;
    // Read word captured in the setup cycle
    if (psel && !penable)
      d.prdata = {24'h000000, rdMux};
    // Register writes, reserved bits stay zero
    if (wr)
    begin
      unique case (idx)
        `IRQ_MCU_CTRL_IDX: d.mcuCtrl = wdat & `IRQ_MCU_CTRL_WMASK;
        `IRQ_EXT_MASK_IDX: d.extMask = wdat & `IRQ_EXT_MASK_WMASK;
        `IRQ_TMR_MASK_IDX: d.tmrMask = wdat & `IRQ_TMR_MASK_WMASK;
        `IRQ_STATUS_IDX: d.gie = wdat[`IRQ_GIE_BIT];
        default: d.gie = d.gie;
      endcase
    end
    // A set in the same cycle as a clear wins
    d.extFlag = setExt | (q.extFlag & ~clrExt);
    d.tmrFlag = setTmr | (q.tmrFlag & ~clrTmr);
    // Level sensing pins keep their flag at zero
    if (q.mcuCtrl[1:0] == `IRQ_SENSE_LEVEL)
      d.extFlag[`IRQ_PIN_A_BIT] = 1'b0;
    if (q.mcuCtrl[3:2] == `IRQ_SENSE_LEVEL)
      d.extFlag[`IRQ_PIN_B_BIT] = 1'b0;
    // Sequencer
    unique case (q.fsm)
      irq_ctl_pkg::S_IDLE:
      begin
        // Return has priority over a new entry
        if (retTake)
        begin
          d.fsm = irq_ctl_pkg::S_RET;
          d.cnt = 3'h0;
        end
        else if (take)
        begin
          d.fsm = irq_ctl_pkg::S_ENTRY;
          d.cnt = 3'h0;
          d.gie = 1'b0;
          d.ans.vecAddr = `IRQ_VEC_BASE + 10'(sel);
        end
      end
      irq_ctl_pkg::S_ENTRY:
      begin
        // Two byte pushes in the middle, four cycles in all
        d.cnt = q.cnt + 3'h1;
        d.ans.push = (q.cnt == 3'h1) | (q.cnt == 3'h2);
        if (q.cnt == `IRQ_ENTRY_CYCLES - 3'h1)
        begin
          d.fsm = irq_ctl_pkg::S_IDLE;
          d.ans.vecValid = 1'b1;
        end
      end
      irq_ctl_pkg::S_RET:
      begin
        // Two byte pops, then the global enable returns
        d.cnt = q.cnt + 3'h1;
        d.ans.pop = (q.cnt == 3'h1) | (q.cnt == 3'h2);
        if (q.cnt == `IRQ_RET_CYCLES - 3'h1)
        begin
          d.fsm = irq_ctl_pkg::S_HOLD;
          d.gie = 1'b1;
        end
      end
      irq_ctl_pkg::S_HOLD:
      begin
        // Wait out one main instruction before serving more
        if (coreReq.instrBoundary)
          d.fsm = irq_ctl_pkg::S_IDLE;
      end
      default:
        d.fsm = irq_ctl_pkg::S_IDLE;
    endcase
  end

  // ****************************************
  // State register
  // ****************************************
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      q <= '0;
      q.fsm <= irq_ctl_pkg::S_IDLE;
      q.mcuCtrl <= `IRQ_REG_RESET;
    end
    else
      q <= d;
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  // Vector strobe five cycles after the take
  chk_entry_delay: assert property (take |-> ##5 q.ans.vecValid)
    else $error("vector strobe not five cycles after take");
  // Exactly two pushes in the entry window
  chk_entry_push: assert property (
    take |-> ##3 q.ans.push ##1 q.ans.push ##1 !q.ans.push)
    else $error("push pattern wrong during entry");
  // Entry masks everything
  chk_entry_gie: assert property (take |=> !q.gie)
    else $error("global enable still set after entry");
  // Return restores enable five cycles after the return starts
  chk_ret_gie: assert property (retTake |-> ##5 q.gie)
    else $error("global enable not set by return");
  // Return parks until one main instruction ends
  chk_ret_hold: assert property (
    retTake |-> ##5 (q.fsm == irq_ctl_pkg::S_HOLD))
    else $error("no hold after return");
  // Level mode flag stays zero
  chk_level_flag: assert property (
    (q.mcuCtrl[1:0] == `IRQ_SENSE_LEVEL) |=>
      !q.extFlag[`IRQ_PIN_A_BIT])
    else $error("pin A flag set in level mode");
  // Edge always lands in the flag
  chk_edge_flag: assert property (edgeA |=> q.extFlag[`IRQ_PIN_A_BIT])
    else $error("pin A edge lost");
  // Capture sets its flag
  chk_cap_flag: assert property (
    timerEvt.captured |=> q.tmrFlag[`IRQ_CAP_BIT])
    else $error("capture flag not set");
  // Write one clears a quiet flag
  chk_w1c_clear: assert property (
    (wr && idx == `IRQ_TMR_FLAG_IDX && wdat[`IRQ_TB_WRAP_BIT]
      && !setTmr[`IRQ_TB_WRAP_BIT]) |=> !q.tmrFlag[`IRQ_TB_WRAP_BIT])
    else $error("timer B wrap flag not cleared");
  // Pin A beats every other source
  chk_prio_pin_a: assert property (
    (take && req[0]) |-> ##5 (q.ans.vecAddr == `IRQ_VEC_BASE))
    else $error("pin A not served first");
  // Held level is served when idle and enabled
  chk_level_req: assert property (
    (levelA && q.extMask[`IRQ_PIN_A_BIT] && q.gie && !coreReq.returnReq
      && coreReq.instrBoundary && q.fsm == irq_ctl_pkg::S_IDLE)
      |-> take)
    else $error("held low level not requested");
  // Pin B edge lands in its own flag
  chk_edge_flag_b: assert property (edgeB |=> q.extFlag[`IRQ_PIN_B_BIT])
    else $error("pin B edge lost");
  // Pin B flag stays zero in level mode too
  chk_level_flag_b: assert property (
    (q.mcuCtrl[3:2] == `IRQ_SENSE_LEVEL) |=>
      !q.extFlag[`IRQ_PIN_B_BIT])
    else $error("pin B flag set in level mode");
  // Exactly two pops in the return window
  chk_ret_pop: assert property (
    retTake |-> ##3 q.ans.pop ##1 q.ans.pop ##1 !q.ans.pop)
    else $error("pop pattern wrong during return");

  // Main scenarios
  cov_entry: cover property (take ##5 q.ans.vecValid);
  cov_return: cover property (retTake ##5 (q.fsm == irq_ctl_pkg::S_HOLD));
  cov_capture: cover property (take && sel == 3'h2);
  cov_level: cover property (take && levelB && sel == 3'h1);
endmodule
`default_nettype wire

// ---- verif/core_model.sv ----
// Core-side model: instruction boundaries, return requests and stack pointer
`timescale 1ns/100ps
`default_nettype none
module core_model (
  input wire logic clk,
  input wire logic nrst,
  input wire logic boundaryEn,
  input wire logic returnCmd,
  input wire irq_ctl_pkg::core_ans_t coreAns,
  output irq_ctl_pkg::core_req_t coreReq,
  output logic [7:0] sp
);
  // ********************
  // Requests and stack
  // ********************
  // Boundary low stands for a multi-cycle instruction still running
  always_comb
  begin
    coreReq.instrBoundary = boundaryEn;
    coreReq.returnReq = returnCmd;
  end
  // One byte per pulse, so a full entry or return moves two
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
      sp <= 8'hDF;
    else if (coreAns.push)
      sp <= sp - 8'h01;
    else if (coreAns.pop)
      sp <= sp + 8'h01;
  end
endmodule
`default_nettype wire

// ---- verif/irq_ctl_tb.sv ----
// Self-checking bench for the interrupt control block
`timescale 1ns/100ps
`default_nettype none
`include "irq_ctl_regs.svh"
module irq_ctl_tb;
  // ********************
  // Signals and tables
  // ********************
  logic clk, nrst, psel, penable, pwrite, pinA, pinB, bnd, retCmd, pready, pslverr, gEn, err;
  logic [7:0] paddr, sp;
  logic [31:0] pwdata, prdata, rd;
  logic [4:0] evt;
  irq_ctl_pkg::core_req_t coreReq;
  irq_ctl_pkg::core_ans_t coreAns;
  int errorCnt, compares, cyc, n, k;
  // Flag bit set by each timer strobe, strobe bit 0 first
  logic [7:0] tab [5] = '{8'h02, 8'h08, 8'h40, 8'h80, 8'h80};
  // Control, ext mask, ext flags, timer mask, timer flags, status
  logic [7:0] adr [6] = '{{`IRQ_MCU_CTRL_IDX, 2'b00}, {`IRQ_EXT_MASK_IDX, 2'b00},
    {`IRQ_EXT_FLAG_IDX, 2'b00}, {`IRQ_TMR_MASK_IDX, 2'b00},
    {`IRQ_TMR_FLAG_IDX, 2'b00}, {`IRQ_STATUS_IDX, 2'b00}};
  irq_ctl dut (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .extIrqPinA(pinA), .extIrqPinB(pinB), .timerEvt(evt), .coreReq(coreReq),
    .coreAns(coreAns), .globalEnable(gEn));
  core_model core (.clk(clk), .nrst(nrst), .boundaryEn(bnd), .returnCmd(retCmd),
    .coreAns(coreAns), .coreReq(coreReq), .sp(sp));
  // ********************
  // Tasks
  // ********************
  task automatic printVerdict;
    begin
      $display("Comparisons %0d, mismatches %0d", compares, errorCnt);
      if (errorCnt == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] got);
    begin
      compares++;
      if (got !== e)
      begin
        errorCnt++;
        $display("[FAIL] %s expected %h seen %h", nm, e, got);
      end
    end
  endtask
  // Idle cycle after release, so psel is never assigned twice in one step
  task automatic apb(input logic w, input logic [7:0] a, input logic [7:0] d);
    begin
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= {24'h000000, d};
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1)
        @(posedge clk);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
    end
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
    begin
      apb(1'b0, a, 8'h00);
      chk($sformatf("reg %h", a), {24'h000000, e}, rd);
    end
  endtask
  // Counts settled cycles until vector strobe or global enable, cap 30
  task automatic waitFor(input logic useGie);
    begin
      n = 0;
      do
      begin
        @(negedge clk);
        n++;
      end
      while ((useGie ? gEn : coreAns.vecValid) !== 1'b1 && n < 30);
      @(posedge clk);
    end
  endtask
  task automatic ent(input int v, input int lat);
    begin
      bnd <= 1'b1;
      waitFor(1'b0);
      bnd <= 1'b0;
      chk("vector", v, coreAns.vecAddr);
      chk("entry latency", lat, n);
      chk("stack after entry", 8'hDD, sp);
      chk("global after entry", 1'b0, gEn);
    end
  endtask
  task automatic retn;
    begin
      retCmd <= 1'b1;
      @(posedge clk);
      retCmd <= 1'b0;
      waitFor(1'b1);
      // Four return cycles, then the cycle that shows the enable
      chk("return latency", 5, n);
      chk("stack after return", 8'hDF, sp);
    end
  endtask
  task automatic noEnt;
    begin
      bnd <= 1'b1;
      waitFor(1'b0);
      bnd <= 1'b0;
      chk("no entry", 30, n);
    end
  endtask
  // ********************
  // Clock, timeout, tests
  // ********************
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // Run needs about 400 cycles
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 6000)
    begin
      errorCnt++;
      printVerdict;
    end
  end
  initial
  begin
    {nrst, psel, penable, pwrite, pinB, bnd, retCmd} = 7'h00;
    pinA = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h00000000;
    evt = 5'h00;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (k = 0; k < 6; k++)
      rdChk(adr[k], 8'h00);
    apb(1'b0, 8'h00, 8'h00);
    chk("unmapped error", 1'b1, err);
    chk("unmapped data", 32'h00000000, rd);
    apb(1'b1, adr[0], 8'hFF);
    rdChk(adr[0], 8'h3F);
    apb(1'b1, adr[1], 8'hFF);
    rdChk(adr[1], 8'hC0);
    apb(1'b1, adr[3], 8'hFF);
    rdChk(adr[3], 8'hCA);
    // Reserved sense code ignores both edges
    apb(1'b1, adr[0], 8'h05);
    pinA <= 1'b0;
    pinB <= 1'b1;
    repeat (6) @(posedge clk);
    pinA <= 1'b1;
    pinB <= 1'b0;
    repeat (6) @(posedge clk);
    rdChk(adr[2], 8'h00);
    // Pin A falling, pin B rising
    apb(1'b1, adr[0], 8'h0E);
    pinA <= 1'b0;
    repeat (6) @(posedge clk);
    rdChk(adr[2], 8'h40);
    pinB <= 1'b1;
    repeat (6) @(posedge clk);
    rdChk(adr[2], 8'hC0);
    apb(1'b1, adr[2], 8'h00);
    rdChk(adr[2], 8'hC0);
    apb(1'b1, adr[2], 8'h40);
    rdChk(adr[2], 8'h80);
    pinA <= 1'b1;
    repeat (6) @(posedge clk);
    pinA <= 1'b0;
    repeat (6) @(posedge clk);
    rdChk(adr[2], 8'hC0);
    for (k = 0; k < 5; k++)
    begin
      evt <= 5'h01 << k;
      @(posedge clk);
      evt <= 5'h00;
      @(posedge clk);
      rdChk(adr[4], tab[k]);
      apb(1'b1, adr[4], 8'h00);
      rdChk(adr[4], tab[k]);
      apb(1'b1, adr[4], tab[k]);
      rdChk(adr[4], 8'h00);
    end
    evt <= 5'h1F;
    @(posedge clk);
    evt <= 5'h00;
    @(posedge clk);
    rdChk(adr[4], 8'hCA);
    noEnt;
    apb(1'b1, adr[5], 8'h80);
    // Take cycle, four entry cycles, strobe cycle; one more to leave the hold
    for (k = 1; k < 7; k++)
    begin
      ent(k, (k == 1) ? 6 : 7);
      retn;
    end
    rdChk(adr[2], 8'h00);
    rdChk(adr[4], 8'h00);
    // Level sensing with pin A still low
    apb(1'b1, adr[0], 8'h00);
    rdChk(adr[2], 8'h00);
    ent(1, 7);
    retn;
    ent(1, 7);
    pinA <= 1'b1;
    retn;
    noEnt;
    // Pin B held low in level mode, served from idle
    pinB <= 1'b0;
    repeat (4) @(posedge clk);
    ent(2, 6);
    pinB <= 1'b1;
    retn;
    printVerdict;
  end
endmodule
`default_nettype wire
